// [core/measurement_fifo_sequencer.sv]
// sequencer that walks the enabled measurement slots each frame, starts one
// conversion per slot and pushes two tagged items per slot toward the data fifo
// assumes converter and fifo run on clk; frameStart and convDone are same-clock pulses
//
// Behaviour
// - enabled slots pushed ascending, tagged; disabled skipped
// - two items per slot: channel one, then two
// - after last slot, next frame restarts lowest
// - ambient off stores corrected exposure result
// - ambient on stores direct ambient sample
// - ambient slot ignores all driver routes
// - zero current makes driver route irrelevant
// - route zero: A pin1, B pin2
// - diode select zero: PD1 ch1, PD2 ch2
// - several drivers may pulse in one slot
// - each item is three bytes
`timescale 1ns/1ns
module measurement_fifo_sequencer (
  input  wire logic                                                   clk,
  input  wire logic                                                   resetn,
  input  wire logic                                                   frameStart,
  input  wire logic [mfs_pkg::SLOT_COUNT-1:0]                         slotEnable,
  input  wire logic [mfs_pkg::SLOT_COUNT-1:0]                         slotAmbientSelect,
  input  wire logic [mfs_pkg::SLOT_COUNT-1:0][mfs_pkg::DRIVER_COUNT-1:0][1:0] slotDriverRoute,
  input  wire logic [mfs_pkg::SLOT_COUNT-1:0][mfs_pkg::DRIVER_COUNT-1:0][7:0] slotDriverCurrent,
  input  wire logic [mfs_pkg::SLOT_COUNT-1:0]                         slotChannelOneDiodeSelect,
  input  wire logic [mfs_pkg::SLOT_COUNT-1:0]                         slotChannelTwoDiodeSelect,
  input  wire logic [mfs_pkg::SLOT_COUNT-1:0][mfs_pkg::GAIN_W-1:0]    slotGainRange,
  input  wire logic [mfs_pkg::SLOT_COUNT-1:0][mfs_pkg::WIDTH_W-1:0]   slotPulseWidth,
  input  wire logic                                                   convDone,
  input  wire logic [mfs_pkg::DATA_W-1:0]                             exposureChannelOne,
  input  wire logic [mfs_pkg::DATA_W-1:0]                             exposureChannelTwo,
  input  wire logic [mfs_pkg::DATA_W-1:0]                             ambientChannelOne,
  input  wire logic [mfs_pkg::DATA_W-1:0]                             ambientChannelTwo,
  input  wire logic                                                   pushReady,
  output logic                                                        convStart,
  output logic                                                        convAmbient,
  output logic [mfs_pkg::DRIVER_COUNT-1:0]                            driverOn,
  output logic [mfs_pkg::DRIVER_COUNT-1:0][7:0]                       driverCurrent,
  output logic [mfs_pkg::DRIVER_COUNT-1:0][3:0]                       driverPin,
  output logic [mfs_pkg::DIODE_W-1:0]                                 channelOneDiode,
  output logic [mfs_pkg::DIODE_W-1:0]                                 channelTwoDiode,
  output logic [mfs_pkg::GAIN_W-1:0]                                  convGainRange,
  output logic [mfs_pkg::WIDTH_W-1:0]                                 convPulseWidth,
  output logic                                                        pushValid,
  output logic [mfs_pkg::ITEM_W-1:0]                                  pushData,
  output logic                                                        pushChannelTwo,
  output logic                                                        busy
);

  // ****************************************
  // declarations
  // ****************************************
  mfs_pkg::mfs_state_e                                        state_r;
  logic [mfs_pkg::SLOT_COUNT-1:0]                             enSnap_r;
  logic [mfs_pkg::SLOT_COUNT-1:0]                             ambSnap_r;
  logic [mfs_pkg::SLOT_COUNT-1:0][mfs_pkg::DRIVER_COUNT-1:0][1:0] routeSnap_r;
  logic [mfs_pkg::SLOT_COUNT-1:0][mfs_pkg::DRIVER_COUNT-1:0][7:0] curSnap_r;
  logic [mfs_pkg::SLOT_COUNT-1:0]                             sel1Snap_r;
  logic [mfs_pkg::SLOT_COUNT-1:0]                             sel2Snap_r;
  logic [mfs_pkg::SLOT_COUNT-1:0][mfs_pkg::GAIN_W-1:0]        gainSnap_r;
  logic [mfs_pkg::SLOT_COUNT-1:0][mfs_pkg::WIDTH_W-1:0]       widthSnap_r;
  logic [mfs_pkg::IDX_W-1:0]                                  searchFrom_r;
  logic [mfs_pkg::IDX_W-1:0]                                  slot_r;
  logic [mfs_pkg::DATA_W-1:0]                                 second_r;
  logic [mfs_pkg::ITEM_W-1:0]                                 pushData_r;
  logic                                                       convStart_r;
  logic                                                       pickFound;
  logic [mfs_pkg::IDX_W-1:0]                                  pickIdx;
  logic [mfs_pkg::TAG_W-1:0]                                  tag;
  logic                                                       pushTake;

  // driver route plus per-driver base gives the led pin; off drivers show no pin
  function automatic logic [mfs_pkg::PIN_W-1:0] pinOf(
    input logic [mfs_pkg::PIN_W-1:0]   base,
    input logic [mfs_pkg::ROUTE_W-1:0] route,
    input logic                        on
  );
    logic [mfs_pkg::PIN_W-1:0] p;
    p = base + {2'h0, route};
    pinOf = on ? p : mfs_pkg::PIN_NONE;
  endfunction : pinOf

  assign tag       = slot_r + mfs_pkg::IDX_ONE;
  assign pushValid = (state_r == mfs_pkg::ST_PUSH1) || (state_r == mfs_pkg::ST_PUSH2);
  assign pushTake  = pushValid && pushReady;
  assign pushData  = pushData_r;
  assign pushChannelTwo = (state_r == mfs_pkg::ST_PUSH2);
  assign busy      = (state_r != mfs_pkg::ST_IDLE);
  assign convStart = convStart_r;

  mfs_slot_picker u_picker (
    .mask    (enSnap_r),
    .fromIdx (searchFrom_r),
    .found   (pickFound),
    .idx     (pickIdx)
  );

  // ****************************************
  // frame snapshot of slot settings
  // ****************************************
  // settings are copied only when a frame starts, so a mid-frame write cannot
  // reorder or half-apply a slot
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      enSnap_r    <= '0;
      ambSnap_r   <= '0;
      routeSnap_r <= '0;
      curSnap_r   <= '0;
      sel1Snap_r  <= '0;
      sel2Snap_r  <= '0;
      gainSnap_r  <= '0;
      widthSnap_r <= '0;
    end
    else if ((state_r == mfs_pkg::ST_IDLE) && frameStart)
    begin
      enSnap_r    <= slotEnable;
      ambSnap_r   <= slotAmbientSelect;
      routeSnap_r <= slotDriverRoute;
      curSnap_r   <= slotDriverCurrent;
      sel1Snap_r  <= slotChannelOneDiodeSelect;
      sel2Snap_r  <= slotChannelTwoDiodeSelect;
      gainSnap_r  <= slotGainRange;
      widthSnap_r <= slotPulseWidth;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r      <= mfs_pkg::ST_IDLE;
      searchFrom_r <= mfs_pkg::IDX_FIRST;
      slot_r       <= mfs_pkg::IDX_FIRST;
    end
    else
    begin
      case (state_r)
        mfs_pkg::ST_IDLE:
        begin
          if (frameStart)
          begin
            searchFrom_r <= mfs_pkg::IDX_FIRST;
            state_r      <= mfs_pkg::ST_SEEK;
          end
        end
        mfs_pkg::ST_SEEK:
        begin
          if (pickFound)
          begin
            slot_r  <= pickIdx;
            state_r <= mfs_pkg::ST_WAIT;
          end
          else
          begin
            state_r <= mfs_pkg::ST_IDLE;
          end
        end
        mfs_pkg::ST_WAIT:
        begin
          if (convDone)
          begin
            state_r <= mfs_pkg::ST_PUSH1;
          end
        end
        mfs_pkg::ST_PUSH1:
        begin
          if (pushReady)
          begin
            state_r <= mfs_pkg::ST_PUSH2;
          end
        end
        mfs_pkg::ST_PUSH2:
        begin
          if (pushReady)
          begin
            searchFrom_r <= slot_r + mfs_pkg::IDX_ONE;
            state_r      <= mfs_pkg::ST_SEEK;
          end
        end
        default:
        begin
          state_r <= mfs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // conversion request and slot settings
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      convStart_r     <= 1'b0;
      convAmbient     <= 1'b0;
      driverOn        <= '0;
      driverCurrent   <= '0;
      driverPin       <= '0;
      channelOneDiode <= mfs_pkg::DIODE_CH1_DEF;
      channelTwoDiode <= mfs_pkg::DIODE_CH2_DEF;
      convGainRange   <= '0;
      convPulseWidth  <= '0;
    end
    else
    begin
      convStart_r <= (state_r == mfs_pkg::ST_SEEK) && pickFound;
      if ((state_r == mfs_pkg::ST_SEEK) && pickFound)
      begin
        convAmbient <= ambSnap_r[pickIdx];
        for (int d = 0; d < mfs_pkg::DRIVER_COUNT; d++)
        begin
          // each driver decided alone, so any mix may fire together
          driverOn[d] <= !ambSnap_r[pickIdx] &&
                         (curSnap_r[pickIdx][d] != mfs_pkg::CURRENT_OFF);
          driverCurrent[d] <= ambSnap_r[pickIdx] ? mfs_pkg::CURRENT_OFF
                                                 : curSnap_r[pickIdx][d];
        end
        driverPin[0] <= pinOf(mfs_pkg::PIN_BASE_A, routeSnap_r[pickIdx][0],
                              !ambSnap_r[pickIdx] &&
                              (curSnap_r[pickIdx][0] != mfs_pkg::CURRENT_OFF));
        driverPin[1] <= pinOf(mfs_pkg::PIN_BASE_B, routeSnap_r[pickIdx][1],
                              !ambSnap_r[pickIdx] &&
                              (curSnap_r[pickIdx][1] != mfs_pkg::CURRENT_OFF));
        driverPin[2] <= pinOf(mfs_pkg::PIN_BASE_C, routeSnap_r[pickIdx][2],
                              !ambSnap_r[pickIdx] &&
                              (curSnap_r[pickIdx][2] != mfs_pkg::CURRENT_OFF));
        channelOneDiode <= sel1Snap_r[pickIdx] ? mfs_pkg::DIODE_CH1_ALT
                                               : mfs_pkg::DIODE_CH1_DEF;
        channelTwoDiode <= sel2Snap_r[pickIdx] ? mfs_pkg::DIODE_CH2_ALT
                                               : mfs_pkg::DIODE_CH2_DEF;
        convGainRange   <= gainSnap_r[pickIdx];
        convPulseWidth  <= widthSnap_r[pickIdx];
      end
    end
  end

  // ****************************************
  // item assembly
  // ****************************************
  // tag in the top nibble, result below: one 24 bit item, three bytes to the host
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pushData_r <= '0;
      second_r   <= '0;
    end
    else if ((state_r == mfs_pkg::ST_WAIT) && convDone)
    begin
      pushData_r <= {tag, ambSnap_r[slot_r] ? ambientChannelOne
                                            : exposureChannelOne};
      second_r   <= ambSnap_r[slot_r] ? ambientChannelTwo : exposureChannelTwo;
    end
    else if ((state_r == mfs_pkg::ST_PUSH1) && pushReady)
    begin
      pushData_r <= {tag, second_r};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [mfs_pkg::TAG_W-1:0] lastTag_r;
  always_ff @(posedge clk)
  begin
    if (!resetn || (state_r == mfs_pkg::ST_IDLE))
      lastTag_r <= '0;
    else if (pushTake && pushChannelTwo)
      lastTag_r <= pushData_r[mfs_pkg::ITEM_W-1:mfs_pkg::TAG_LSB];
  end

  a_tag_enabled: assert property (@(posedge clk) disable iff (!resetn)
    pushValid |-> enSnap_r[slot_r] && (pushData[23:20] == slot_r + 4'h1))
    else $error("pushed item tag wrong or slot disabled");

  a_tag_ascending: assert property (@(posedge clk) disable iff (!resetn)
    (pushValid && !pushChannelTwo) |-> (pushData[23:20] > lastTag_r))
    else $error("slot order not ascending in frame");

  a_pair_order: assert property (@(posedge clk) disable iff (!resetn)
    (pushTake && !pushChannelTwo) |=> pushValid && pushChannelTwo && $stable(slot_r)
      && (pushData[23:20] == $past(pushData[23:20])))
    else $error("second channel item missing after first");

  a_frame_restart: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == mfs_pkg::ST_IDLE) && frameStart |=> (searchFrom_r == 4'h0))
    else $error("frame does not restart at lowest slot");

  a_result_source: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == mfs_pkg::ST_WAIT) && convDone && !ambSnap_r[slot_r]
      |=> pushData[19:0] == $past(exposureChannelOne))
    else $error("exposure result not stored");

  a_ambient_source: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == mfs_pkg::ST_WAIT) && convDone && ambSnap_r[slot_r]
      |=> pushData[19:0] == $past(ambientChannelOne))
    else $error("ambient sample not stored");

  a_ambient_drivers: assert property (@(posedge clk) disable iff (!resetn)
    convStart && convAmbient |-> (driverOn == 3'h0) && (driverPin == '0))
    else $error("driver active in ambient slot");

  a_zero_current: assert property (@(posedge clk) disable iff (!resetn)
    convStart && (driverCurrent[1] == 8'h00) |-> !driverOn[1] && (driverPin[1] == 4'h0))
    else $error("driver with zero current routed");

  a_route_zero: assert property (@(posedge clk) disable iff (!resetn)
    convStart && driverOn[0] && (routeSnap_r[slot_r][0] == 2'h0) |-> driverPin[0] == 4'h1)
    else $error("driver a default route not pin one");

  a_diode_default: assert property (@(posedge clk) disable iff (!resetn)
    convStart && !sel2Snap_r[slot_r] |-> channelTwoDiode == 3'h2)
    else $error("channel two default diode wrong");

  a_snap_stable: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == mfs_pkg::ST_WAIT) |-> $stable(enSnap_r) && $stable(curSnap_r))
    else $error("settings changed inside a frame");

  c_two_drivers: cover property (@(posedge clk) disable iff (!resetn)
    convStart && driverOn[0] && driverOn[1]);
  c_ambient_push: cover property (@(posedge clk) disable iff (!resetn)
    pushTake && convAmbient);
  c_frame_wrap: cover property (@(posedge clk) disable iff (!resetn)
    (pushTake && pushChannelTwo) ##[1:3] (state_r == mfs_pkg::ST_IDLE));
  c_stalled_push: cover property (@(posedge clk) disable iff (!resetn)
    pushValid && !pushReady ##1 pushTake);

endmodule : measurement_fifo_sequencer

// [core/mfs_pkg.sv]
// shared constants and the sequencer state encoding for the measurement fifo sequencer
// assumes one clock domain; every user of these names writes mfs_pkg::name
package mfs_pkg;

  // ****************************************
  // sizes and item layout
  // ****************************************
  localparam int unsigned SLOT_COUNT   = 9;
  localparam int unsigned IDX_W        = 4;
  localparam int unsigned TAG_W        = 4;
  localparam int unsigned DATA_W       = 20;
  localparam int unsigned ITEM_W       = 24;
  localparam int unsigned ITEM_BYTES   = 3;
  localparam int unsigned TAG_LSB      = 20;
  localparam int unsigned DRIVER_COUNT = 3;
  localparam int unsigned ROUTE_W      = 2;
  localparam int unsigned CURRENT_W    = 8;
  localparam int unsigned PIN_W        = 4;
  localparam int unsigned DIODE_W      = 3;
  localparam int unsigned GAIN_W       = 4;
  localparam int unsigned WIDTH_W      = 2;

  // ****************************************
  // reset and encoding values
  // ****************************************
  localparam logic [IDX_W-1:0]     IDX_FIRST      = 4'h0;
  localparam logic [IDX_W-1:0]     IDX_ONE        = 4'h1;
  localparam logic [CURRENT_W-1:0] CURRENT_OFF    = 8'h00;
  localparam logic [ROUTE_W-1:0]   ROUTE_DEFAULT  = 2'h0;
  localparam logic [PIN_W-1:0]     PIN_NONE       = 4'h0;
  localparam logic [PIN_W-1:0]     PIN_BASE_A     = 4'h1;
  localparam logic [PIN_W-1:0]     PIN_BASE_B     = 4'h2;
  localparam logic [PIN_W-1:0]     PIN_BASE_C     = 4'h3;
  localparam logic [DIODE_W-1:0]   DIODE_CH1_DEF  = 3'h1;
  localparam logic [DIODE_W-1:0]   DIODE_CH1_ALT  = 3'h3;
  localparam logic [DIODE_W-1:0]   DIODE_CH2_DEF  = 3'h2;
  localparam logic [DIODE_W-1:0]   DIODE_CH2_ALT  = 3'h4;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SEEK  = 5'h02,
    ST_WAIT  = 5'h04,
    ST_PUSH1 = 5'h08,
    ST_PUSH2 = 5'h10
  } mfs_state_e;

endpackage : mfs_pkg

// [core/mfs_slot_picker.sv]
// lowest enabled slot at or above a start index
// assumes a combinational caller on the same clock; no state here
`timescale 1ns/1ns
module mfs_slot_picker (
  input  wire logic [mfs_pkg::SLOT_COUNT-1:0] mask,
  input  wire logic [mfs_pkg::IDX_W-1:0]      fromIdx,
  output logic                                found,
  output logic [mfs_pkg::IDX_W-1:0]           idx
);

  // ****************************************
  // priority search, lowest index wins
  // ****************************************
  always_comb
  begin
    found = 1'b0;
    idx   = mfs_pkg::IDX_FIRST;
    for (int i = mfs_pkg::SLOT_COUNT - 1; i >= 0; i--)
    begin
      if (mask[i] && (i[mfs_pkg::IDX_W-1:0] >= fromIdx))
      begin
        found = 1'b1;
        idx   = i[mfs_pkg::IDX_W-1:0];
      end
    end
  end

endmodule : mfs_slot_picker

// [tb/mfs_host_model.sv]
// far side model: slot converter plus the fifo writer that feeds the host byte stream
// assumes one clock with the sequencer; lat and stall come from the bench
`timescale 1ns/1ns
module mfs_host_model (
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic                       convStart,
  input  wire logic                       pushValid,
  input  wire logic [mfs_pkg::ITEM_W-1:0] pushData,
  input  wire logic [3:0]                 lat,
  input  wire logic                       stall,
  output logic                            convDone,
  output logic [mfs_pkg::DATA_W-1:0]      exposureChannelOne,
  output logic [mfs_pkg::DATA_W-1:0]      exposureChannelTwo,
  output logic [mfs_pkg::DATA_W-1:0]      ambientChannelOne,
  output logic [mfs_pkg::DATA_W-1:0]      ambientChannelTwo,
  output logic                            pushReady
);
  logic [3:0]  wait_r    = 4'h0;
  logic [15:0] count_r   = 16'h0000;
  logic [1:0]  stall_r   = 2'h0;
  int          byteCount = 0;

  // results are only meaningful in the done cycle; otherwise show a changing junk pattern
  assign exposureChannelOne = convDone ? {4'h1, count_r} : {4'hE, ~count_r};
  assign exposureChannelTwo = convDone ? {4'h2, count_r} : {4'hD, ~count_r};
  assign ambientChannelOne  = convDone ? {4'h3, count_r} : {4'hC, ~count_r};
  assign ambientChannelTwo  = convDone ? {4'h4, count_r} : {4'hB, ~count_r};
  // stalled writer accepts one cycle in four
  assign pushReady = stall ? (stall_r == 2'h3) : 1'b1;

  // convDone has this one driver; it is unknown only until the first reset edge
  always @(posedge clk)
  begin
    stall_r <= stall_r + 2'h1;
    if (!resetn)
    begin
      wait_r   <= 4'h0;
      count_r  <= 16'h0000;
      convDone <= 1'b0;
    end
    else
    begin
      convDone <= 1'b0;
      if (convDone)
        count_r <= count_r + 16'h0001;
      if (convStart)
        wait_r <= lat;
      else if (wait_r != 4'h0)
      begin
        wait_r   <= wait_r - 4'h1;
        convDone <= (wait_r == 4'h1);
      end
      if (pushValid && pushReady)
        byteCount <= byteCount + 3;
    end
  end
endmodule : mfs_host_model

// [tb/tb.sv]
// self-checking bench for the measurement fifo sequencer
// assumes mfs_host_model stands in for the converter and the fifo writer
`timescale 1ns/1ns
module tb;
  localparam int N = mfs_pkg::SLOT_COUNT;
  typedef struct packed {logic [8:0] e; logic [8:0] a; logic [3:0] l; logic s; logic [3:0] n;}
    mfs_row_s;
  logic                   clk = 1'b0;
  logic                   resetn = 1'b0;
  logic                   frameStart = 1'b0;
  logic [N-1:0]           en = '0, amb = '0, sel1 = 9'h0F0, sel2 = 9'h155;
  logic [N-1:0][2:0][1:0] route;
  logic [N-1:0][2:0][7:0] cur;
  logic [N-1:0][3:0]      gain;
  logic [N-1:0][1:0]      width;
  logic [N-1:0]           sAmb, sEn, sSel1, sSel2;
  logic [N-1:0][2:0][1:0] sRoute;
  logic [N-1:0][2:0][7:0] sCur;
  logic [N-1:0][3:0]      sGain;
  logic [N-1:0][1:0]      sWidth;
  logic convDone, convStart, convAmbient, pushReady, pushValid, pushChannelTwo, busy;
  logic [19:0]            exp1, exp2, amb1, amb2;
  logic [2:0]             driverOn;
  logic [2:0][7:0]        driverCurrent;
  logic [2:0][3:0]        driverPin;
  logic [2:0]             ch1Diode, ch2Diode;
  logic [3:0]             convGain;
  logic [1:0]             convWidth;
  logic [23:0]            pushData;
  logic [3:0]             lat = 4'h1;
  logic                   stall = 1'b0;
  int num_errors = 0, tests_run = 0, lastSlot = -1, curSlot = 0, convIdx = 0;
  int frConv = 0, frItem = 0, itemCh = 0, b0 = 0;
  mfs_row_s rows [6] = '{'{9'h007, 9'h004, 4'h1, 1'b0, 4'h3}, '{9'h009, 9'h008, 4'h3, 1'b1, 4'h2},
    '{9'h1FF, 9'h0AA, 4'h2, 1'b1, 4'h9}, '{9'h100, 9'h000, 4'h1, 1'b0, 4'h1},
    '{9'h000, 9'h000, 4'h1, 1'b0, 4'h0}, '{9'h111, 9'h101, 4'h5, 1'b1, 4'h3}};

  measurement_fifo_sequencer uut (.clk(clk), .resetn(resetn), .frameStart(frameStart),
    .slotEnable(en), .slotAmbientSelect(amb), .slotDriverRoute(route), .slotDriverCurrent(cur),
    .slotChannelOneDiodeSelect(sel1), .slotChannelTwoDiodeSelect(sel2), .slotGainRange(gain),
    .slotPulseWidth(width), .convDone(convDone), .exposureChannelOne(exp1),
    .exposureChannelTwo(exp2), .ambientChannelOne(amb1), .ambientChannelTwo(amb2),
    .pushReady(pushReady), .convStart(convStart), .convAmbient(convAmbient), .driverOn(driverOn),
    .driverCurrent(driverCurrent), .driverPin(driverPin), .channelOneDiode(ch1Diode),
    .channelTwoDiode(ch2Diode), .convGainRange(convGain), .convPulseWidth(convWidth),
    .pushValid(pushValid), .pushData(pushData), .pushChannelTwo(pushChannelTwo), .busy(busy));

  mfs_host_model host (.clk(clk), .resetn(resetn), .convStart(convStart), .pushValid(pushValid),
    .pushData(pushData), .lat(lat), .stall(stall), .convDone(convDone),
    .exposureChannelOne(exp1), .exposureChannelTwo(exp2), .ambientChannelOne(amb1),
    .ambientChannelTwo(amb2), .pushReady(pushReady));

  always #4 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    tests_run++;
    if (got !== expv)
    begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", what, expv, got);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic check_settings(input int s);
    logic on;
    for (int d = 0; d < 3; d++)
    begin
      on = !sAmb[s] && sCur[s][d] != 8'h00;
      chk("driver on", on, driverOn[d]);
      chk("driver current", on ? sCur[s][d] : 8'h00, driverCurrent[d]);
      chk("driver pin", on ? 4'h1 + 4'(d) + 4'(sRoute[s][d]) : 4'h0, driverPin[d]);
    end
    chk("ambient mode", sAmb[s], convAmbient);
    chk("diode one", sSel1[s] ? mfs_pkg::DIODE_CH1_ALT : mfs_pkg::DIODE_CH1_DEF, ch1Diode);
    chk("diode two", sSel2[s] ? mfs_pkg::DIODE_CH2_ALT : mfs_pkg::DIODE_CH2_DEF, ch2Diode);
    chk("gain", sGain[s], convGain);
    chk("width", sWidth[s], convWidth);
  endtask : check_settings

  // ****************************************
  // monitor: expected slot walk from the snapshot taken at frame start
  // ****************************************
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      lastSlot = -1;
      convIdx = 0;
    end
    else
    begin
      if (convStart === 1'b1)
      begin
        curSlot = lastSlot + 1;
        while (curSlot < N && !sEn[curSlot])
          curSlot++;
        chk("slot found", 1, curSlot < N);
        if (curSlot < N)
          check_settings(curSlot);
        lastSlot = curSlot;
        convIdx++;
        frConv++;
        itemCh = 0;
      end
      if (pushValid === 1'b1 && pushReady === 1'b1)
      begin
        chk("item tag", curSlot + 1, pushData[23:20]);
        chk("item channel", itemCh, pushChannelTwo);
        chk("item data", {4'h1 + 4'(itemCh) + (sAmb[curSlot] ? 4'h2 : 4'h0), 16'(convIdx - 1)},
            pushData[19:0]);
        itemCh ^= 1;
        frItem++;
      end
    end
  end

  // called just after a clock edge; settings are frozen in the snapshot at the next edge
  task automatic start_frame(input logic [N-1:0] e, input logic [N-1:0] a);
    en = e;
    amb = a;
    {sEn, sAmb, sSel1, sSel2} = {e, a, sel1, sel2};
    {sRoute, sCur, sGain, sWidth} = {route, cur, gain, width};
    lastSlot = -1;
    frConv = 0;
    frItem = 0;
    b0 = host.byteCount;
    frameStart = 1'b1;
    @(posedge clk);
    #1 frameStart = 1'b0;
  endtask : start_frame

  task automatic end_frame(input int n);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("busy end", 0, busy);
    chk("frame conversions", n, frConv);
    chk("frame items", 2 * n, frItem);
    chk("frame bytes", 6 * n, host.byteCount - b0);
  endtask : end_frame

  initial
  begin
    #(8 * 50000);
    num_errors++;
    final_report();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    for (int s = 0; s < N; s++)
    begin
      gain[s] = 4'(s);
      width[s] = 2'(s);
      for (int d = 0; d < 3; d++)
      begin
        route[s][d] = 2'(s + d);
        cur[s][d] = (s == 0 || (s + d) % 3 == 0) ? 8'h0B + 8'(s * 3 + d) : 8'h00;
      end
    end
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    chk("reset busy", 0, busy);
    chk("reset valid", 0, pushValid);
    chk("reset start", 0, convStart);
    chk("reset data", 0, pushData);
    chk("reset drivers", 0, driverOn);
    chk("reset diodes", {3'h1, 3'h2}, {ch1Diode, ch2Diode});
    // each row runs two frames back to back so the restart at the lowest slot is seen
    for (int r = 0; r < 6; r++)
    begin
      lat = rows[r].l;
      stall = rows[r].s;
      repeat (2)
      begin
        start_frame(rows[r].e, rows[r].a);
        end_frame(rows[r].n);
      end
    end
    // settings and a second frame request arrive mid-frame; neither may disturb it
    start_frame(9'h007, 9'h004);
    repeat (3) @(posedge clk);
    #1 en = 9'h1FF;
    amb = 9'h1FF;
    cur[0][0] = 8'h00;
    route[1] = '0;
    frameStart = 1'b1;
    @(posedge clk);
    #1 frameStart = 1'b0;
    end_frame(3);
    // reset in mid-frame, then a fresh frame must start clean from the lowest slot
    start_frame(9'h1FF, 9'h000);
    repeat (10) @(posedge clk);
    #1 resetn = 1'b0;
    @(posedge clk);
    #1 resetn = 1'b1;
    chk("abort busy", 0, busy);
    chk("abort valid", 0, pushValid);
    start_frame(9'h003, 9'h002);
    end_frame(2);
    final_report();
  end
endmodule : tb
